// ### complementary_waveform_control_tb.sv
// Self-checking testbench of the waveform generator core
`timescale 1ns/1ns
`default_nettype none
module complementary_waveform_control_tb;
	logic        CLOCK_I;
	logic        RST_B_I;
	logic        CE_I;
	logic [3:0]  ADDR_I;
	logic [7:0]  WDATA_I;
	logic        WR_I;
	logic        RD_I;
	logic [7:0]  RDATA_O;
	logic [31:0] SOURCES_I;
	logic [6:0]  SHUTDOWN_B_I;
	logic        SLEEP_I;
	logic        FAST_OSC_SELECT_O;
	logic        FAST_OSC_KEEP_O;
	logic [3:0]  WAVE_O;
	logic [3:0]  WAVE_OE_B_O;
	logic [3:0]  pins;
	int          n_mismatch;
	int          tests_run;
	integer      seed;
	logic [7:0]  q;
	logic [31:0] src;
	logic [3:0]  st;
	logic [3:0]  ov;
	logic [3:0]  inv;
	logic [4:0]  sel;
	int          r;

	wavegen_core DUT (
		.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .CE_I(CE_I),
		.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
		.SOURCES_I(SOURCES_I), .SHUTDOWN_B_I(SHUTDOWN_B_I), .SLEEP_I(SLEEP_I),
		.FAST_OSC_SELECT_O(FAST_OSC_SELECT_O), .FAST_OSC_KEEP_O(FAST_OSC_KEEP_O),
		.WAVE_O(WAVE_O), .WAVE_OE_B_O(WAVE_OE_B_O)
	);

	wavegen_bridge_model bridge (
		.clk_i(CLOCK_I), .rst_b_i(RST_B_I), .wave_i(WAVE_O), .oe_b_i(WAVE_OE_B_O), .pin_o(pins)
	);

	// ----------------------------------------------------------------
	// Clock, bus tasks and checks
	// ----------------------------------------------------------------
	initial begin
		CLOCK_I = 1'b0;
		forever #5 CLOCK_I = ~CLOCK_I;
	end

	task automatic conclude();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
			n_mismatch++;
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge CLOCK_I);
		ADDR_I <= a;
		WDATA_I <= d;
		WR_I <= 1'b1;
		@(posedge CLOCK_I);
		WR_I <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge CLOCK_I);
		ADDR_I <= a;
		RD_I <= 1'b1;
		@(posedge CLOCK_I);
		RD_I <= 1'b0;
		#1 d = RDATA_O;
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(d, e);
	endtask

	// Output registered one cycle after the register edge
	task automatic settle();
		repeat (2) @(posedge CLOCK_I);
		#1;
	endtask

	function automatic logic [3:0] steer_exp(input logic [3:0] s, input logic [3:0] o,
			input logic [3:0] p, input logic d);
		for (int i = 0; i < 4; i++) begin
			steer_exp[i] = s[i] ? (d ^ p[i]) : o[i];
		end
	endfunction

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		n_mismatch = 0;
		tests_run = 0;
		seed = 32'h5e1b;
		RST_B_I = 1'b0;
		CE_I = 1'b1;
		ADDR_I = 4'h0;
		WDATA_I = 8'h00;
		WR_I = 1'b0;
		RD_I = 1'b0;
		SOURCES_I = 32'h0;
		SHUTDOWN_B_I = 7'h7f;
		SLEEP_I = 1'b0;
		repeat (3) @(posedge CLOCK_I);
		RST_B_I <= 1'b1;
		rdchk(wavegen_pkg::ADDR_CONTROL_0, 8'h00);
		rdchk(wavegen_pkg::ADDR_CLOCK_SELECT, 8'h00);
		rdchk(wavegen_pkg::ADDR_STEERING, 8'h00);
		rdchk(4'hf, 8'h00);
		rd(wavegen_pkg::ADDR_CONTROL_1, q);
		chk(q & 8'hdf, 8'h00);
		// Setup while disabled, then enable with a same-cycle load request
		inv = 4'h6;
		wr(wavegen_pkg::ADDR_CONTROL_1, {4'h0, inv});
		wr(wavegen_pkg::ADDR_SHUTDOWN_0, 8'h2c);
		wr(wavegen_pkg::ADDR_CONTROL_0, 8'hf8);
		rdchk(wavegen_pkg::ADDR_CONTROL_0, 8'h80);
		rdchk(wavegen_pkg::ADDR_SHUTDOWN_0, 8'hac);
		settle();
		chk({4'h0, pins}, 8'h05);
		wr(wavegen_pkg::ADDR_SHUTDOWN_0, 8'h9c);
		settle();
		chk({4'h0, WAVE_OE_B_O}, 8'h0a);
		chk({4'h0, pins}, 8'h0f);
		wr(wavegen_pkg::ADDR_SHUTDOWN_0, 8'h80);
		settle();
		chk({WAVE_OE_B_O, WAVE_O}, {4'h0, inv});
		// Clear refused while a gated source is active
		wr(wavegen_pkg::ADDR_SHUTDOWN_1, 8'h01);
		SHUTDOWN_B_I <= 7'h7e;
		wr(wavegen_pkg::ADDR_SHUTDOWN_0, 8'h2c);
		rdchk(wavegen_pkg::ADDR_SHUTDOWN_0, 8'hac);
		SHUTDOWN_B_I <= 7'h7f;
		wr(wavegen_pkg::ADDR_SHUTDOWN_0, 8'h2c);
		rdchk(wavegen_pkg::ADDR_SHUTDOWN_0, 8'h2c);
		@(posedge CLOCK_I);
		SOURCES_I <= 32'hffff_ffff;
		settle();
		// Asynchronous steering with random configuration
		for (int k = 0; k < 12; k++) begin
			r = $unsigned($random(seed)) % 17;
			sel = (r > 8) ? 5'(r + 2) : 5'(r);
			src = $random(seed);
			{ov, st} = 8'($random(seed));
			inv = 4'($random(seed));
			if (k == 0) begin
				sel = wavegen_pkg::SEL_LAST;
			end
			SOURCES_I <= src;
			wr(wavegen_pkg::ADDR_CONTROL_1, {4'h0, inv});
			wr(wavegen_pkg::ADDR_INPUT_SELECT, {3'h0, sel});
			wr(wavegen_pkg::ADDR_STEERING, {ov, st});
			settle();
			chk({4'h0, pins}, {4'h0, steer_exp(st, ov, inv, src[sel])});
			rd(wavegen_pkg::ADDR_CONTROL_1, q);
			chk({7'h0, q[wavegen_pkg::BIT_IN_LEVEL]}, {7'h0, src[sel]});
		end
		// Every mode code, reserved ones give inactive outputs
		for (int m = 0; m < 8; m++) begin
			wr(wavegen_pkg::ADDR_CONTROL_0, 8'h80 | 8'(m));
			rdchk(wavegen_pkg::ADDR_CONTROL_0, 8'h80 | 8'(m));
			if (m > 5) begin
				settle();
				chk({4'h0, WAVE_O}, {4'h0, inv});
			end
		end
		wr(wavegen_pkg::ADDR_CONTROL_0, 8'h80);
		for (int c = 9; c < 32; c++) begin
			if (c < 11 || c > 18) begin
				wr(wavegen_pkg::ADDR_INPUT_SELECT, 8'(c));
				settle();
				chk({4'h0, WAVE_O}, {4'h0, inv});
			end
		end
		// Fast oscillator request in sleep
		wr(wavegen_pkg::ADDR_INPUT_SELECT, 8'h00);
		wr(wavegen_pkg::ADDR_CLOCK_SELECT, 8'h01);
		rdchk(wavegen_pkg::ADDR_CLOCK_SELECT, 8'h01);
		chk({7'h0, FAST_OSC_SELECT_O}, 8'h01);
		SLEEP_I <= 1'b1;
		settle();
		chk({7'h0, FAST_OSC_KEEP_O}, 8'h01);
		wr(wavegen_pkg::ADDR_INPUT_SELECT, 8'h09);
		settle();
		chk({7'h0, FAST_OSC_KEEP_O}, 8'h00);
		wr(wavegen_pkg::ADDR_INPUT_SELECT, 8'h00);
		wr(wavegen_pkg::ADDR_CLOCK_SELECT, 8'h00);
		settle();
		chk({6'h0, FAST_OSC_SELECT_O, FAST_OSC_KEEP_O}, 8'h00);
		SLEEP_I <= 1'b0;
		// Hardware shutdown, then automatic restart
		SHUTDOWN_B_I <= 7'h7e;
		settle();
		rdchk(wavegen_pkg::ADDR_SHUTDOWN_0, 8'hac);
		wr(wavegen_pkg::ADDR_SHUTDOWN_0, 8'hec);
		SHUTDOWN_B_I <= 7'h7f;
		q = 8'hff;
		for (int i = 0; i < 8 && q[7] !== 1'b0; i++) begin
			rd(wavegen_pkg::ADDR_SHUTDOWN_0, q);
		end
		chk(q, 8'h6c);
		if (q[7] !== 1'b0) begin
			conclude();
		end
		// Load request waits for a falling then rising data edge
		SOURCES_I <= 32'hffff_ffff;
		wr(wavegen_pkg::ADDR_CONTROL_0, 8'hc0);
		rdchk(wavegen_pkg::ADDR_CONTROL_0, 8'hc0);
		SOURCES_I <= 32'h0;
		settle();
		SOURCES_I <= 32'hffff_ffff;
		settle();
		rdchk(wavegen_pkg::ADDR_CONTROL_0, 8'h80);
		// Synchronous steering holds new enables until a rising data edge
		wr(wavegen_pkg::ADDR_STEERING, 8'h00);
		wr(wavegen_pkg::ADDR_CONTROL_0, 8'h81);
		wr(wavegen_pkg::ADDR_STEERING, 8'h0f);
		settle();
		chk({4'h0, WAVE_O}, 8'h00);
		SOURCES_I <= 32'h0;
		settle();
		SOURCES_I <= 32'hffff_ffff;
		settle();
		chk({4'h0, WAVE_O}, {4'h0, steer_exp(4'hf, 4'h0, inv, 1'b1)});
		// Half bridge, zero dead band: A follows data, B its inverse
		wr(wavegen_pkg::ADDR_CONTROL_0, 8'h84);
		settle();
		chk({4'h0, WAVE_O}, {4'h0, 4'h1 ^ inv});
		SOURCES_I <= 32'h0;
		settle();
		chk({4'h0, WAVE_O}, {4'h0, 4'h2 ^ inv});
		// Clock enable low: a write is not taken
		CE_I <= 1'b0;
		wr(wavegen_pkg::ADDR_CLOCK_SELECT, 8'h01);
		CE_I <= 1'b1;
		rdchk(wavegen_pkg::ADDR_CLOCK_SELECT, 8'h00);
		conclude();
	end
endmodule
`default_nettype wire

// ### wavegen_bridge_model.sv
// Partner model: external bridge driver inputs seen through the output pins
`timescale 1ns/1ns
`default_nettype none
module wavegen_bridge_model (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	// Generator outputs
	input  wire logic [3:0] wave_i,
	input  wire logic [3:0] oe_b_i,
	// Resolved pin levels
	output logic      [3:0] pin_o
);
	logic [3:0] last_reg;

	// ----------------------------------------------------------------
	// Pin resolution
	// ----------------------------------------------------------------
	// No pull on these lines: a floated pin shows the inverse of its last level
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			last_reg <= 4'h0;
		end else begin
			last_reg <= (wave_i & ~oe_b_i) | (last_reg & oe_b_i);
		end
	end

	assign pin_o = (wave_i & ~oe_b_i) | (~last_reg & oe_b_i);
endmodule
`default_nettype wire

// ### wavegen_core.sv
// Complementary waveform generator: registers, steering, bridge modes and shutdown
// ----------------------------------------------------------------------------
// Overview of operation
// - Runs from its own selected clock, keeps running through sleep.
// - Fast oscillator request held in sleep when enabled, input active, selected.
// - After enable the generator starts in shutdown; override levels must be set.
// - Output starts via auto restart or a software clear of shutdown.
// - Control 0 bit 7 enables the generator, reset 0.
// - Load bit loads dead-band buffers on rising edge after falling edge, self clears.
// - Load bit only settable when enable already 1.
// - Three bit mode field selects steering, bridge, half bridge, push-pull.
// - Control 1 bit 5 reads current selected data input level.
// - Clock select bit picks fast oscillator when 1, system clock when 0.
// - Five bit input select routes data input; reserved codes listed.
// - Steering enable passes data with polarity, else override data bit.
// - Synchronous steering double-buffers steering enables.
// - Unimplemented bits read zero.
// - Auto restart clears shutdown when conditions gone; resume on rising data edge.
// - Two bit override fields give one, zero, float or inactive level.
// - Software clear of shutdown refused while a condition persists.
// ----------------------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module wavegen_core (
	// Clock and reset
	input  wire logic        CLOCK_I,
	input  wire logic        RST_B_I,
	input  wire logic        CE_I,
	// Register port
	input  wire logic [3:0]  ADDR_I,
	input  wire logic [7:0]  WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic      [7:0]  RDATA_O,
	// Sources and shutdown inputs (active low)
	input  wire logic [31:0] SOURCES_I,
	input  wire logic [6:0]  SHUTDOWN_B_I,
	// Power management
	input  wire logic        SLEEP_I,
	output logic             FAST_OSC_SELECT_O,
	output logic             FAST_OSC_KEEP_O,
	// Outputs A to D, enable low while driven
	output logic      [3:0]  WAVE_O,
	output logic      [3:0]  WAVE_OE_B_O
);
	typedef struct packed {
		logic       enable;
		logic       load;
		logic [2:0] mode;
		logic [3:0] invert;
		logic       clk_sel;
		logic [4:0] input_select;
		logic [3:0] override_data;
		logic [3:0] steer_enable;
		logic [3:0] steer_active;
		logic       shutdown;
		logic       restart;
		logic [1:0] level_bd;
		logic [1:0] level_ac;
		logic [6:0] sources;
		logic [5:0] rise_db;
		logic [5:0] fall_db;
		logic [5:0] rise_db_buf;
		logic [5:0] fall_db_buf;
		logic       seen_fall;
		logic       data_d;
		logic       run;
		logic [7:0] rdata;
		logic [3:0] wave;
		logic [3:0] oe_b;
		logic       fwd_last;
	} core_state_t;
	core_state_t s_reg, s_next;

	logic data_in;
	logic sel_valid;
	logic rise_busy;
	logic fall_busy;
	logic condition;
	logic rise_edge;
	logic fall_edge;
	logic dir_to_rev;
	logic dir_to_fwd;
	logic wr_c0;
	logic wr_as0;

	// ------------------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------------------
	wavegen_input_mux u_mux (
		.sel_i     (s_reg.input_select),
		.sources_i (SOURCES_I),
		.data_o    (data_in),
		.valid_o   (sel_valid)
	);

	wavegen_deadband u_rise_db (
		.clk_i   (CLOCK_I),
		.rst_b_i (RST_B_I),
		.ce_i    (CE_I),
		.start_i (rise_edge | dir_to_rev),
		.abort_i (fall_edge),
		.count_i (s_reg.rise_db_buf),
		.busy_o  (rise_busy)
	);

	wavegen_deadband u_fall_db (
		.clk_i   (CLOCK_I),
		.rst_b_i (RST_B_I),
		.ce_i    (CE_I),
		.start_i (fall_edge | dir_to_fwd),
		.abort_i (rise_edge),
		.count_i (s_reg.fall_db_buf),
		.busy_o  (fall_busy)
	);

	// Per-pair level for a shutdown override field
	function automatic logic [1:0] ovr_level(input logic [1:0] lvl, input logic inv);
		ovr_level[0] = (lvl == wavegen_pkg::LVL_HIGH) ? 1'b1 :
			(lvl == wavegen_pkg::LVL_INACTIVE) ? inv : 1'b0;
		ovr_level[1] = (lvl == wavegen_pkg::LVL_FLOAT);
	endfunction

	assign rise_edge  = data_in & ~s_reg.data_d;
	assign fall_edge  = ~data_in & s_reg.data_d;
	assign dir_to_rev = rise_edge && s_reg.fwd_last && (s_reg.mode == wavegen_pkg::MODE_REV_FULL);
	assign dir_to_fwd = rise_edge && !s_reg.fwd_last && (s_reg.mode == wavegen_pkg::MODE_FWD_FULL);
	assign condition  = |(s_reg.sources & ~SHUTDOWN_B_I);
	assign wr_c0      = WR_I && (ADDR_I == wavegen_pkg::ADDR_CONTROL_0);
	assign wr_as0     = WR_I && (ADDR_I == wavegen_pkg::ADDR_SHUTDOWN_0);

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		logic [3:0] raw;
		logic [1:0] lac;
		logic [1:0] lbd;
		logic       legal;
		raw   = 4'h0;
		lac   = 2'h0;
		lbd   = 2'h0;
		legal = 1'b0;
		s_next = s_reg;
		s_next.data_d = data_in;

		// Register writes
		if (WR_I) begin
			if (ADDR_I == wavegen_pkg::ADDR_CONTROL_0) begin
				s_next.enable = WDATA_I[wavegen_pkg::BIT_ENABLE];
				s_next.mode   = WDATA_I[2:0];
				if (WDATA_I[wavegen_pkg::BIT_LOAD] && s_reg.enable) begin
					s_next.load      = 1'b1;
					s_next.seen_fall = 1'b0;
				end
			end else if (ADDR_I == wavegen_pkg::ADDR_CONTROL_1) begin
				s_next.invert = WDATA_I[3:0];
			end else if (ADDR_I == wavegen_pkg::ADDR_CLOCK_SELECT) begin
				s_next.clk_sel = WDATA_I[0];
			end else if (ADDR_I == wavegen_pkg::ADDR_INPUT_SELECT) begin
				s_next.input_select = WDATA_I[4:0];
			end else if (ADDR_I == wavegen_pkg::ADDR_STEERING) begin
				s_next.override_data = WDATA_I[7:wavegen_pkg::OVR_LSB];
				s_next.steer_enable  = WDATA_I[3:0];
			end else if (ADDR_I == wavegen_pkg::ADDR_SHUTDOWN_0) begin
				s_next.restart  = WDATA_I[wavegen_pkg::BIT_RESTART];
				s_next.level_bd = WDATA_I[5:wavegen_pkg::LVL_BD_LSB];
				s_next.level_ac = WDATA_I[3:wavegen_pkg::LVL_AC_LSB];
				if (WDATA_I[wavegen_pkg::BIT_SHUTDOWN]) begin
					s_next.shutdown = 1'b1;
				end else if (!condition) begin
					s_next.shutdown = 1'b0;
				end
			end else if (ADDR_I == wavegen_pkg::ADDR_SHUTDOWN_1) begin
				s_next.sources = WDATA_I[6:0];
			end else if (ADDR_I == wavegen_pkg::ADDR_RISE_DB) begin
				s_next.rise_db = WDATA_I[5:0];
				if (!s_reg.enable) begin
					s_next.rise_db_buf = WDATA_I[5:0];
				end
			end else if (ADDR_I == wavegen_pkg::ADDR_FALL_DB) begin
				s_next.fall_db = WDATA_I[5:0];
				if (!s_reg.enable) begin
					s_next.fall_db_buf = WDATA_I[5:0];
				end
			end
		end

		// Enabling enters shutdown and stops output
		if (wr_c0 && WDATA_I[wavegen_pkg::BIT_ENABLE] && !s_reg.enable) begin
			s_next.shutdown = 1'b1;
			s_next.run      = 1'b0;
		end

		// Hardware set wins over any clear
		if (s_reg.enable && condition) begin
			s_next.shutdown = 1'b1;
		end else if (s_reg.enable && s_reg.restart && !condition && !(wr_as0 &&
				WDATA_I[wavegen_pkg::BIT_SHUTDOWN])) begin
			s_next.shutdown = 1'b0;
		end
		if (s_next.shutdown) begin
			s_next.run = 1'b0;
		end else if (rise_edge) begin
			s_next.run = 1'b1;
		end

		// Buffer load handshake
		if (s_reg.load) begin
			if (fall_edge) begin
				s_next.seen_fall = 1'b1;
			end
			if (s_reg.seen_fall && rise_edge) begin
				s_next.rise_db_buf = s_reg.rise_db;
				s_next.fall_db_buf = s_reg.fall_db;
				// A software set in the same cycle wins over the hardware clear
				s_next.load        = wr_c0 && WDATA_I[wavegen_pkg::BIT_LOAD] && s_reg.enable;
			end
		end

		// Steering enables double-buffered in synchronous mode
		if (s_reg.mode == wavegen_pkg::MODE_SYNC_STEER) begin
			if (rise_edge) begin
				s_next.steer_active = s_reg.steer_enable;
			end
		end else begin
			s_next.steer_active = s_next.steer_enable;
		end
		if (rise_edge) begin
			s_next.fwd_last = (s_reg.mode == wavegen_pkg::MODE_FWD_FULL);
		end

		// Output waveform before polarity
		legal = sel_valid && (s_reg.mode <= wavegen_pkg::MODE_PUSH_PULL);
		if (s_reg.mode == wavegen_pkg::MODE_ASYNC_STEER ||
				s_reg.mode == wavegen_pkg::MODE_SYNC_STEER) begin
			raw = 4'h0;
		end else if (s_reg.mode == wavegen_pkg::MODE_HALF) begin
			raw = {1'b0, 1'b0, ~data_in & ~fall_busy, data_in & ~rise_busy};
		end else if (s_reg.mode == wavegen_pkg::MODE_PUSH_PULL) begin
			raw = {1'b0, 1'b0, ~data_in & s_reg.data_d, data_in};
		end else if (s_reg.mode == wavegen_pkg::MODE_FWD_FULL) begin
			raw = {data_in & ~fall_busy, 1'b0, 1'b0, 1'b1};
		end else if (s_reg.mode == wavegen_pkg::MODE_REV_FULL) begin
			raw = {1'b0, 1'b1, data_in & ~rise_busy, 1'b0};
		end
		s_next.wave = raw ^ s_reg.invert;
		if (s_reg.mode == wavegen_pkg::MODE_ASYNC_STEER ||
				s_reg.mode == wavegen_pkg::MODE_SYNC_STEER) begin
			for (int i = 0; i < 4; i++) begin
				s_next.wave[i] = s_next.steer_active[i] ? (data_in ^ s_reg.invert[i])
					: s_next.override_data[i];
			end
		end
		s_next.oe_b = 4'h0;
		if (!s_reg.enable || !legal) begin
			s_next.wave = s_reg.invert;
		end else if (s_reg.shutdown || !s_reg.run) begin
			lac = ovr_level(s_reg.level_ac, s_reg.invert[0]);
			s_next.wave[0] = lac[0];
			s_next.oe_b[0] = lac[1];
			lac = ovr_level(s_reg.level_ac, s_reg.invert[2]);
			s_next.wave[2] = lac[0];
			s_next.oe_b[2] = lac[1];
			lbd = ovr_level(s_reg.level_bd, s_reg.invert[1]);
			s_next.wave[1] = lbd[0];
			s_next.oe_b[1] = lbd[1];
			lbd = ovr_level(s_reg.level_bd, s_reg.invert[3]);
			s_next.wave[3] = lbd[0];
			s_next.oe_b[3] = lbd[1];
		end

		// Read data, one cycle after the strobe
		s_next.rdata = wavegen_pkg::RESET_BYTE;
		if (RD_I) begin
			if (ADDR_I == wavegen_pkg::ADDR_CONTROL_0) begin
				s_next.rdata = {s_reg.enable, s_reg.load, 3'h0, s_reg.mode};
			end else if (ADDR_I == wavegen_pkg::ADDR_CONTROL_1) begin
				s_next.rdata = {2'h0, data_in, 1'b0, s_reg.invert};
			end else if (ADDR_I == wavegen_pkg::ADDR_CLOCK_SELECT) begin
				s_next.rdata = {7'h00, s_reg.clk_sel};
			end else if (ADDR_I == wavegen_pkg::ADDR_INPUT_SELECT) begin
				s_next.rdata = {3'h0, s_reg.input_select};
			end else if (ADDR_I == wavegen_pkg::ADDR_STEERING) begin
				s_next.rdata = {s_reg.override_data, s_reg.steer_enable};
			end else if (ADDR_I == wavegen_pkg::ADDR_SHUTDOWN_0) begin
				s_next.rdata = {s_reg.shutdown, s_reg.restart, s_reg.level_bd, s_reg.level_ac,
					2'h0};
			end else if (ADDR_I == wavegen_pkg::ADDR_SHUTDOWN_1) begin
				s_next.rdata = {1'b0, s_reg.sources};
			end else if (ADDR_I == wavegen_pkg::ADDR_RISE_DB) begin
				s_next.rdata = {2'h0, s_reg.rise_db};
			end else if (ADDR_I == wavegen_pkg::ADDR_FALL_DB) begin
				s_next.rdata = {2'h0, s_reg.fall_db};
			end
		end
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------
	// Clock enable low freezes all registered state; FAST_OSC_KEEP_O still follows SLEEP_I
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			s_reg <= '0;
		end else if (CE_I) begin
			s_reg <= s_next;
		end
	end

	assign RDATA_O           = s_reg.rdata;
	assign WAVE_O            = s_reg.wave;
	assign WAVE_OE_B_O       = s_reg.oe_b;
	assign FAST_OSC_SELECT_O = s_reg.clk_sel;
	// Sleep does not gate this block; it keeps its oscillator alive
	assign FAST_OSC_KEEP_O   = SLEEP_I && s_reg.enable && s_reg.clk_sel && sel_valid;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	sequence load_request_s;
		wr_c0 && WDATA_I[wavegen_pkg::BIT_LOAD] && !s_reg.enable && CE_I;
	endsequence

	enable_load_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
		(load_request_s and !s_reg.load) |=> !s_reg.load)
		else $error("load bit set together with enable");

	enable_write_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
		wr_c0 && CE_I |=> s_reg.enable == $past(WDATA_I[wavegen_pkg::BIT_ENABLE]))
		else $error("enable bit not written");

	start_shutdown_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
		wr_c0 && CE_I && WDATA_I[wavegen_pkg::BIT_ENABLE] && !s_reg.enable |=> s_reg.shutdown)
		else $error("enable did not enter shutdown");

	clear_refused_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
		wr_as0 && CE_I && condition && s_reg.enable |=> s_reg.shutdown)
		else $error("shutdown cleared while condition present");

	reserved_idle_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
		CE_I && (s_reg.mode > wavegen_pkg::MODE_PUSH_PULL) |=> WAVE_O == $past(s_reg.invert))
		else $error("reserved mode not inactive");

	read_zero_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
		RD_I && CE_I && ADDR_I == wavegen_pkg::ADDR_CONTROL_0 |=> RDATA_O[5:3] == 3'h0)
		else $error("unimplemented bits read nonzero");

	keep_osc_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
		FAST_OSC_KEEP_O |-> s_reg.enable && s_reg.clk_sel && SLEEP_I)
		else $error("oscillator kept without cause");

	load_clear_a: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
		CE_I && s_reg.load && s_reg.seen_fall && rise_edge |=>
			s_reg.load == $past(wr_c0 && WDATA_I[wavegen_pkg::BIT_LOAD] && s_reg.enable) &&
			s_reg.rise_db_buf == $past(s_reg.rise_db))
		else $error("buffers not loaded");
endmodule
`default_nettype wire

// ### wavegen_deadband.sv
// Dead-band delay counter for one edge
`timescale 1ns/1ns
`default_nettype none
module wavegen_deadband (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       ce_i,
	// Control
	input  wire logic       start_i,
	input  wire logic       abort_i,
	input  wire logic [5:0] count_i,
	// Status
	output logic            busy_o
);
	typedef struct packed {
		logic [5:0] cnt;
		logic       busy;
	} db_state_t;
	db_state_t s_reg, s_next;

	always_comb begin
		s_next = s_reg;
		if (abort_i) begin
			s_next.busy = 1'b0;
		end else if (start_i) begin
			s_next.cnt  = count_i;
			s_next.busy = (count_i != wavegen_pkg::RESET_DB);
		end else if (s_reg.busy) begin
			s_next.cnt  = s_reg.cnt - wavegen_pkg::DB_STEP;
			s_next.busy = (s_reg.cnt != wavegen_pkg::DB_STEP);
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_reg <= '0;
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	assign busy_o = s_reg.busy;
endmodule
`default_nettype wire

// ### wavegen_input_mux.sv
// Data input multiplexer with reserved-code detection
`timescale 1ns/1ns
`default_nettype none
module wavegen_input_mux (
	// Selection
	input  wire logic [4:0]  sel_i,
	// Sources, index equals select code
	input  wire logic [31:0] sources_i,
	// Result
	output logic             data_o,
	output logic             valid_o
);
	always_comb begin
		valid_o = (sel_i <= wavegen_pkg::SEL_LAST_LOW) ||
			((sel_i >= wavegen_pkg::SEL_FIRST_HIGH) && (sel_i <= wavegen_pkg::SEL_LAST));
		data_o = valid_o & sources_i[sel_i];
	end
endmodule
`default_nettype wire

// ### wavegen_pkg.sv
// Package: register map, field layout, reset values and encodings of the waveform generator
package wavegen_pkg;
	// Register indices
	localparam logic [3:0] ADDR_CONTROL_0    = 4'h0;
	localparam logic [3:0] ADDR_CONTROL_1    = 4'h1;
	localparam logic [3:0] ADDR_CLOCK_SELECT = 4'h2;
	localparam logic [3:0] ADDR_INPUT_SELECT = 4'h3;
	localparam logic [3:0] ADDR_STEERING     = 4'h4;
	localparam logic [3:0] ADDR_SHUTDOWN_0   = 4'h5;
	localparam logic [3:0] ADDR_SHUTDOWN_1   = 4'h6;
	localparam logic [3:0] ADDR_RISE_DB      = 4'h7;
	localparam logic [3:0] ADDR_FALL_DB      = 4'h8;

	// Field positions
	localparam int BIT_ENABLE    = 7;
	localparam int BIT_LOAD      = 6;
	localparam int BIT_IN_LEVEL  = 5;
	localparam int BIT_SHUTDOWN  = 7;
	localparam int BIT_RESTART   = 6;
	localparam int LVL_BD_LSB    = 4;
	localparam int LVL_AC_LSB    = 2;
	localparam int OVR_LSB       = 4;

	// Reset values and dead-band count step
	localparam logic [7:0] RESET_BYTE     = 8'h00;
	localparam logic [5:0] RESET_DB       = 6'h00;
	localparam logic [3:0] RESET_NIBBLE   = 4'h0;
	localparam logic [1:0] RESET_LEVEL    = 2'h0;
	localparam logic [6:0] RESET_SOURCES  = 7'h00;
	localparam logic [5:0] DB_STEP        = 6'h01;

	// Mode encodings
	localparam logic [2:0] MODE_ASYNC_STEER = 3'h0;
	localparam logic [2:0] MODE_SYNC_STEER  = 3'h1;
	localparam logic [2:0] MODE_FWD_FULL    = 3'h2;
	localparam logic [2:0] MODE_REV_FULL    = 3'h3;
	localparam logic [2:0] MODE_HALF        = 3'h4;
	localparam logic [2:0] MODE_PUSH_PULL   = 3'h5;

	// Input select range
	localparam logic [4:0] SEL_LAST_LOW   = 5'h08;
	localparam logic [4:0] SEL_FIRST_HIGH = 5'h0b;
	localparam logic [4:0] SEL_LAST       = 5'h12;

	// Shutdown override encodings
	localparam logic [1:0] LVL_INACTIVE = 2'h0;
	localparam logic [1:0] LVL_FLOAT    = 2'h1;
	localparam logic [1:0] LVL_LOW      = 2'h2;
	localparam logic [1:0] LVL_HIGH     = 2'h3;
endpackage
